// ### pci_phase_pkg.sv
package pci_phase_pkg;
  localparam int AD_W       = 32;
  localparam int CBE_W      = 4;
  localparam int LEN_W      = 4;
  localparam int FIFO_DEPTH = 8;
  localparam int SYNC_W     = AD_W + CBE_W + 5;

  // Bus commands the target side answers
  localparam logic [CBE_W-1:0] CMD_MEM_READ  = 4'h6;
  localparam logic [CBE_W-1:0] CMD_MEM_WRITE = 4'h7;
  // All byte lanes enabled during data phases (active low)
  localparam logic [CBE_W-1:0] BE_ALL        = 4'h0;

  localparam logic [AD_W-1:0]  TGT_BASE      = 32'h1000_0000;
  localparam logic [AD_W-1:0]  TGT_MASK      = 32'hffff_0000;
  localparam logic [AD_W-1:0]  AD_RESET      = 32'h0000_0000;
  localparam logic [LEN_W-1:0] LEN_ONE       = 4'h1;

  typedef enum logic [3:0] {
    M_IDLE = 4'b0001,
    M_ADDR = 4'b0010,
    M_DATA = 4'b0100,
    M_END  = 4'b1000
  } mst_state_t;

  typedef enum logic [2:0] {
    T_IDLE = 3'b001,
    T_DATA = 3'b010,
    T_END  = 3'b100
  } tgt_state_t;
endpackage

// ### pci_phase_handshake.sv
// Functional notes
// [RQ1] Reset pin low resets every block; the input synchronizer flops and frame_q reset on reset_in only
// [RQ2] System holds reset pin low 10 ms
// [RQ3] Parity even over AD and C/BE
// [RQ4] Master drives address/write parity, target read
// [RQ5] Master frame low at address, high before last
// [RQ6] Target decodes address when frame asserts
// [RQ7] Master ready marks write data, read acceptance
// [RQ8] Target samples initiator ready for data
// [RQ9] Target ready marks read data, write acceptance
// [RQ10] Master completes phase only on target ready
// [RQ11] Parity driven one clock after its phase
`timescale 1ns/1ps

module pci_word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  output logic      [WIDTH-1:0] out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp, rp, next_wp, next_rp;
  logic [AW:0]      cnt, next_cnt;
  logic             room, next_room, push, pop;

  assign push          = in_valid_in & room;
  assign pop           = out_ready_in & out_valid_out;
  assign in_ready_out  = room;
  assign out_valid_out = (cnt != '0);
  assign out_data_out  = mem[rp];

  always_comb begin
    next_wp   = push ? AW'(wp + 1'b1) : wp;
    next_rp   = pop ? AW'(rp + 1'b1) : rp;
    next_cnt  = cnt + (AW+1)'(push) - (AW+1)'(pop);
    // Registered room keeps the fill-side ready straight from a flop
    next_room = (next_cnt != (AW+1)'(DEPTH));
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      wp   <= '0;
      rp   <= '0;
      cnt  <= '0;
      room <= 1'b1;
    end else begin
      wp   <= next_wp;
      rp   <= next_rp;
      cnt  <= next_cnt;
      room <= next_room;
    end
  end

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wp] <= in_data_in;
    end
  end
endmodule

module pci_phase_handshake #(
  parameter logic [31:0] TGT_BASE   = pci_phase_pkg::TGT_BASE,
  parameter logic [31:0] TGT_MASK   = pci_phase_pkg::TGT_MASK,
  parameter int          FIFO_DEPTH = pci_phase_pkg::FIFO_DEPTH
) (
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic        chip_reset_low_in,
  input  wire logic        frame_in,
  output logic             frame_out,
  output logic             frame_oe_out,
  input  wire logic        irdy_in,
  output logic             irdy_out,
  output logic             irdy_oe_out,
  input  wire logic        trdy_in,
  output logic             trdy_out,
  output logic             trdy_oe_out,
  input  wire logic        par_in,
  output logic             par_out,
  output logic             par_oe_out,
  input  wire logic [31:0] ad_in,
  output logic      [31:0] ad_out,
  output logic             ad_oe_out,
  input  wire logic [3:0]  cbe_in,
  output logic      [3:0]  cbe_out,
  output logic             cbe_oe_out,
  input  wire logic        mst_start_in,
  input  wire logic        mst_write_in,
  input  wire logic [31:0] mst_addr_in,
  input  wire logic [3:0]  mst_cmd_in,
  input  wire logic [3:0]  mst_count_in,
  output logic             mst_busy_out,
  input  wire logic [31:0] wr_data_in,
  input  wire logic        wr_valid_in,
  output logic             wr_ready_out,
  output logic      [31:0] rd_data_out,
  output logic             rd_valid_out,
  input  wire logic [31:0] tgt_rdata_in,
  output logic      [31:0] tgt_wdata_out,
  output logic             tgt_wvalid_out
);
  ////////////////////////////////////////////////////////////////////////////
  logic [pci_phase_pkg::SYNC_W-1:0] sync1, sync2;
  logic        rst, rst_low_s, frame_s, irdy_s, trdy_s, frame_q;
  logic [31:0] ad_s;
  logic [3:0]  cbe_s, cbe_bus;

  // Pins are asynchronous to clk_in; parity pin kept for pin symmetry
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      sync1   <= '1;
      sync2   <= '1;
      frame_q <= 1'b1;
    end else begin
      sync1   <= {chip_reset_low_in, frame_in, irdy_in, trdy_in, par_in,
                  cbe_in, ad_in};
      sync2   <= sync1;
      frame_q <= frame_s;
    end
  end
  assign {rst_low_s, frame_s, irdy_s, trdy_s} = sync2[40:37];
  assign cbe_s   = sync2[35:32];
  assign ad_s    = sync2[31:0];
  assign rst     = reset_in | ~rst_low_s; // RQ1
  assign cbe_bus = cbe_oe_out ? cbe_out : cbe_s;

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] fifo_data;
  logic        fifo_valid, pop;

  pci_word_fifo #(
    .WIDTH (32),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .clk_in        (clk_in),
    .reset_in      (rst),
    .in_data_in    (wr_data_in),
    .in_valid_in   (wr_valid_in),
    .in_ready_out  (wr_ready_out),
    .out_data_out  (fifo_data),
    .out_valid_out (fifo_valid),
    .out_ready_in  (pop)
  );

  ////////////////////////////////////////////////////////////////////////////
  pci_phase_pkg::mst_state_t m_state, next_m_state;
  pci_phase_pkg::tgt_state_t t_state, next_t_state;
  logic [3:0]  m_left, next_m_left;
  logic        m_write, next_m_write, t_write, next_t_write;
  logic        next_frame, next_frame_oe, next_irdy, next_irdy_oe;
  logic        next_trdy, next_trdy_oe, next_par, next_par_oe;
  logic [31:0] next_ad, next_rd_data, next_tgt_wdata;
  logic        next_ad_oe, next_cbe_oe, next_busy;
  logic        next_rd_valid, next_tgt_wvalid;
  logic [3:0]  next_cbe;
  logic        m_done, t_done, t_hit;

  // Master phase ends only when both ready lines are low
  assign m_done = ~irdy_out & ~trdy_s; // RQ10
  assign t_done = ~irdy_s & ~trdy_out; // RQ8
  assign t_hit  = ((ad_s & TGT_MASK) == (TGT_BASE & TGT_MASK)) &&
                  (cbe_s == pci_phase_pkg::CMD_MEM_READ ||
                   cbe_s == pci_phase_pkg::CMD_MEM_WRITE);

  always_comb begin
    next_m_state    = m_state;
    next_t_state    = t_state;
    next_m_left     = m_left;
    next_m_write    = m_write;
    next_t_write    = t_write;
    next_frame      = frame_out;
    next_frame_oe   = frame_oe_out;
    next_irdy       = irdy_out;
    next_irdy_oe    = irdy_oe_out;
    next_trdy       = trdy_out;
    next_trdy_oe    = trdy_oe_out;
    next_ad         = ad_out;
    next_ad_oe      = ad_oe_out;
    next_cbe        = cbe_out;
    next_cbe_oe     = cbe_oe_out;
    next_busy       = mst_busy_out;
    next_rd_data    = rd_data_out;
    next_rd_valid   = 1'b0;
    next_tgt_wdata  = tgt_wdata_out;
    next_tgt_wvalid = 1'b0;
    pop             = 1'b0;
    // Parity of the phase just driven, presented one clock later
    next_par    = ^{ad_out, cbe_bus}; // RQ3 RQ11
    next_par_oe = ad_oe_out; // RQ4

    case (m_state)
      pci_phase_pkg::M_IDLE: begin
        // Own target busy or foreign frame active blocks a start
        if (mst_start_in && frame_s && t_state == pci_phase_pkg::T_IDLE) begin
          next_m_state  = pci_phase_pkg::M_ADDR;
          next_m_write  = mst_write_in;
          next_m_left   = (mst_count_in == 4'h0) ? pci_phase_pkg::LEN_ONE
                                                 : mst_count_in;
          next_frame    = 1'b0; // RQ5
          next_frame_oe = 1'b1;
          next_irdy     = 1'b1;
          next_irdy_oe  = 1'b1;
          next_ad       = mst_addr_in;
          next_ad_oe    = 1'b1;
          next_cbe      = mst_cmd_in;
          next_cbe_oe   = 1'b1;
          next_busy     = 1'b1;
        end
      end
      pci_phase_pkg::M_ADDR: begin
        next_m_state = pci_phase_pkg::M_DATA;
        next_cbe     = pci_phase_pkg::BE_ALL;
        if (m_write) begin
          next_irdy = ~fifo_valid; // RQ7
          next_ad   = fifo_data;
          pop       = fifo_valid;
          next_frame = fifo_valid && m_left == pci_phase_pkg::LEN_ONE;
        end else begin
          next_ad_oe = 1'b0;
          next_irdy  = 1'b0; // RQ7
          next_frame = (m_left == pci_phase_pkg::LEN_ONE); // RQ5
        end
      end
      pci_phase_pkg::M_DATA: begin
        if (m_done) begin // RQ10
          next_m_left = m_left - 4'h1;
          if (!m_write) begin
            next_rd_data  = ad_s;
            next_rd_valid = 1'b1;
          end
          if (m_left == pci_phase_pkg::LEN_ONE) begin
            next_m_state = pci_phase_pkg::M_END;
            next_irdy    = 1'b1;
            next_frame   = 1'b1;
            next_ad_oe   = 1'b0;
          end else if (m_write) begin
            next_irdy  = ~fifo_valid; // RQ7
            next_ad    = fifo_data;
            pop        = fifo_valid;
            next_frame = fifo_valid && m_left == 4'h2; // RQ5
          end else begin
            next_frame = (m_left == 4'h2); // RQ5
          end
        end else if (m_write && irdy_out && fifo_valid) begin
          // Write data waited on the FIFO; present it now
          next_irdy  = 1'b0; // RQ7
          next_ad    = fifo_data;
          pop        = 1'b1;
          next_frame = (m_left == pci_phase_pkg::LEN_ONE); // RQ5
        end
      end
      pci_phase_pkg::M_END: begin
        next_m_state  = pci_phase_pkg::M_IDLE;
        next_frame_oe = 1'b0;
        next_irdy_oe  = 1'b0;
        next_cbe_oe   = 1'b0;
        next_busy     = 1'b0;
      end
      default: next_m_state = pci_phase_pkg::M_IDLE;
    endcase

    case (t_state)
      pci_phase_pkg::T_IDLE: begin
        // Address is only looked at on the frame's falling edge
        if (!frame_s && frame_q && t_hit &&
            m_state == pci_phase_pkg::M_IDLE) begin // RQ6
          next_t_state = pci_phase_pkg::T_DATA;
          next_t_write = (cbe_s == pci_phase_pkg::CMD_MEM_WRITE);
          next_trdy    = 1'b0; // RQ9
          next_trdy_oe = 1'b1;
          if (cbe_s == pci_phase_pkg::CMD_MEM_READ) begin
            next_ad    = tgt_rdata_in; // RQ9
            next_ad_oe = 1'b1; // RQ4
          end
        end
      end
      pci_phase_pkg::T_DATA: begin
        if (t_done) begin // RQ8
          if (t_write) begin
            next_tgt_wdata  = ad_s;
            next_tgt_wvalid = 1'b1;
          end else begin
            next_ad = tgt_rdata_in;
          end
          if (frame_s) begin
            next_t_state = pci_phase_pkg::T_END;
            next_trdy    = 1'b1;
            next_ad_oe   = 1'b0;
          end
        end
      end
      pci_phase_pkg::T_END: begin
        next_t_state = pci_phase_pkg::T_IDLE;
        next_trdy_oe = 1'b0;
      end
      default: next_t_state = pci_phase_pkg::T_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst) begin // RQ1
      m_state        <= pci_phase_pkg::M_IDLE;
      t_state        <= pci_phase_pkg::T_IDLE;
      m_left         <= 4'h0;
      m_write        <= 1'b0;
      t_write        <= 1'b0;
      frame_out      <= 1'b1;
      frame_oe_out   <= 1'b0;
      irdy_out       <= 1'b1;
      irdy_oe_out    <= 1'b0;
      trdy_out       <= 1'b1;
      trdy_oe_out    <= 1'b0;
      par_out        <= 1'b0;
      par_oe_out     <= 1'b0;
      ad_out         <= pci_phase_pkg::AD_RESET;
      ad_oe_out      <= 1'b0;
      cbe_out        <= 4'hf;
      cbe_oe_out     <= 1'b0;
      mst_busy_out   <= 1'b0;
      rd_data_out    <= pci_phase_pkg::AD_RESET;
      rd_valid_out   <= 1'b0;
      tgt_wdata_out  <= pci_phase_pkg::AD_RESET;
      tgt_wvalid_out <= 1'b0;
    end else begin
      m_state        <= next_m_state;
      t_state        <= next_t_state;
      m_left         <= next_m_left;
      m_write        <= next_m_write;
      t_write        <= next_t_write;
      frame_out      <= next_frame;
      frame_oe_out   <= next_frame_oe;
      irdy_out       <= next_irdy;
      irdy_oe_out    <= next_irdy_oe;
      trdy_out       <= next_trdy;
      trdy_oe_out    <= next_trdy_oe;
      par_out        <= next_par;
      par_oe_out     <= next_par_oe;
      ad_out         <= next_ad;
      ad_oe_out      <= next_ad_oe;
      cbe_out        <= next_cbe;
      cbe_oe_out     <= next_cbe_oe;
      mst_busy_out   <= next_busy;
      rd_data_out    <= next_rd_data;
      rd_valid_out   <= next_rd_valid;
      tgt_wdata_out  <= next_tgt_wdata;
      tgt_wvalid_out <= next_tgt_wvalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst);

  property p_reset_quiet;
    $fell(rst) |-> !frame_oe_out && !irdy_oe_out && !trdy_oe_out && !ad_oe_out;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) // RQ1
    else $error("Pin driven right after reset");

  property p_par_even;
    ad_oe_out |=> par_oe_out && (par_out == ^{$past(ad_out), $past(cbe_bus)});
  endproperty
  a_par_even: assert property (p_par_even) // RQ3
    else $error("Parity not even over previous phase");

  property p_par_owner;
    par_oe_out |-> $past(ad_oe_out);
  endproperty
  a_par_owner: assert property (p_par_owner) // RQ4
    else $error("Parity driven for a phase not owned");

  property p_par_delay;
    $rose(ad_oe_out) |=> $rose(par_oe_out);
  endproperty
  a_par_delay: assert property (p_par_delay) // RQ11
    else $error("Parity not one clock after phase");

  property p_frame_addr;
    m_state == pci_phase_pkg::M_ADDR |-> frame_oe_out && !frame_out &&
      ad_oe_out && $past(m_state == pci_phase_pkg::M_IDLE);
  endproperty
  a_frame_addr: assert property (p_frame_addr) // RQ5
    else $error("Frame not low in address phase");

  property p_frame_last;
    m_state == pci_phase_pkg::M_DATA && !irdy_out &&
      m_left == pci_phase_pkg::LEN_ONE |-> frame_out;
  endproperty
  a_frame_last: assert property (p_frame_last) // RQ5
    else $error("Frame still low in last data phase");

  property p_irdy_write;
    m_state == pci_phase_pkg::M_DATA && m_write && !irdy_out |-> ad_oe_out;
  endproperty
  a_irdy_write: assert property (p_irdy_write) // RQ7
    else $error("Initiator ready without write data");

  property p_tgt_decode;
    $rose(t_state == pci_phase_pkg::T_DATA) |->
      $past(!frame_s && frame_q) && !trdy_out;
  endproperty
  a_tgt_decode: assert property (p_tgt_decode) // RQ6
    else $error("Target claimed without frame edge");

  property p_tgt_write;
    tgt_wvalid_out |-> $past(!irdy_s && !trdy_out && t_write);
  endproperty
  a_tgt_write: assert property (p_tgt_write) // RQ8
    else $error("Write taken without initiator ready");

  property p_trdy_read;
    t_state == pci_phase_pkg::T_DATA && !t_write && !trdy_out |-> ad_oe_out;
  endproperty
  a_trdy_read: assert property (p_trdy_read) // RQ9
    else $error("Target ready without read data");

  property p_rd_complete;
    rd_valid_out |-> $past(!trdy_s && !irdy_out && !m_write);
  endproperty
  a_rd_complete: assert property (p_rd_complete) // RQ10
    else $error("Read completed without target ready");

  c_mst_write: cover property (m_state == pci_phase_pkg::M_END && m_write);
  c_mst_read:  cover property (rd_valid_out && m_state == pci_phase_pkg::M_END);
  c_tgt_write: cover property (tgt_wvalid_out);
  c_tgt_read:  cover property (t_state == pci_phase_pkg::T_END && !t_write);
endmodule

// ### pci_bus_agent.sv
`timescale 1ns/1ps

// Far-side agent: target for the block's master cycles, initiator for
// cycles aimed at the block's target side
module pci_bus_agent (
  input  wire logic        clk_in,
  input  wire logic        frame_in,
  input  wire logic        irdy_in,
  input  wire logic        trdy_in,
  input  wire logic [31:0] ad_in,
  input  wire logic [3:0]  cbe_in,
  output logic             frame_out,
  output logic             frame_oe_out,
  output logic             irdy_out,
  output logic             irdy_oe_out,
  output logic             trdy_out,
  output logic             trdy_oe_out,
  output logic             par_out,
  output logic             par_oe_out,
  output logic      [31:0] ad_out,
  output logic             ad_oe_out,
  output logic      [3:0]  cbe_out,
  output logic             cbe_oe_out
);
  logic [31:0] rd_q[$], wr_q[$], init_q[$], got_q[$], last_addr;
  logic        last_q[$], init_act, wr;
  logic [3:0]  last_cmd, cb;
  int          n_addr, stall;

  ////////////////////////////////////////////////////////////////////////
  task automatic serve;
    int w;
    w = 0;
    while (w < 300) begin
      @(posedge clk_in);
      w++;
      if (irdy_in === 1'b0) begin
        // Ready held one cycle: the block syncs it, longer counts twice
        repeat (stall) @(negedge clk_in);
        @(negedge clk_in);
        {trdy_oe_out, trdy_out, ad_oe_out} = {2'b10, !wr};
        if (!wr) ad_out = rd_q.pop_front();
        @(posedge clk_in);
        if (wr) wr_q.push_back(ad_in);
        last_q.push_back(frame_in);
        cb = cbe_in;
        @(negedge clk_in);
        {trdy_out, ad_oe_out, par_oe_out} = {2'b10, !wr};
        par_out = ^{ad_out, cb};
        @(negedge clk_in);
        {trdy_oe_out, par_oe_out} = 2'b00;
        repeat (2) @(posedge clk_in);
      end else if (frame_in === 1'b1) begin
        w = 300;
      end
    end
  endtask

  task automatic initiate(input logic [31:0] a, input logic [3:0] c,
                          input int n);
    int k;
    int w;
    init_act = 1'b1;
    @(negedge clk_in);
    {frame_oe_out, frame_out, ad_oe_out, cbe_oe_out} = 4'b1011;
    {irdy_oe_out, irdy_out, ad_out, cbe_out} = {2'b11, a, c};
    for (k = 0; k < n; k++) begin
      @(negedge clk_in);
      {cbe_out, ad_oe_out} = {pci_phase_pkg::BE_ALL, c[0]};
      if (c[0] && init_q.size() > 0) ad_out = init_q.pop_front();
      w = 0;
      do begin
        @(posedge clk_in);
        w++;
      end while (trdy_in !== 1'b0 && w < 40);
      // One-cycle ready per phase; frame rises with the final one
      @(negedge clk_in);
      {irdy_out, frame_out} = {1'b0, k == n - 1};
      @(posedge clk_in);
      if (!c[0]) got_q.push_back(ad_in);
      @(negedge clk_in);
      // Write data parity stands one clock after its phase
      par_out = ^{ad_out, cbe_out};
      {irdy_out, par_oe_out} = {1'b1, c[0]};
      @(negedge clk_in);
      par_oe_out = 1'b0;
      repeat (2) @(posedge clk_in);
    end
    @(negedge clk_in);
    {frame_oe_out, ad_oe_out, cbe_oe_out} = 3'b000;
    @(negedge clk_in);
    irdy_oe_out = 1'b0;
    repeat (4) @(negedge clk_in);
    init_act = 1'b0;
  endtask

  initial begin
    {frame_oe_out, irdy_oe_out, trdy_oe_out, par_oe_out} = 4'h0;
    {ad_oe_out, cbe_oe_out, init_act, n_addr, stall} = 67'h0;
    {frame_out, irdy_out, trdy_out, par_out, cbe_out} = 8'hff;
    ad_out = 32'h0;
    forever begin
      @(posedge clk_in);
      if (frame_in === 1'b0 && !init_act) begin
        {wr, last_addr, last_cmd} = {cbe_in[0], ad_in, cbe_in};
        n_addr++;
        serve();
      end
    end
  end
endmodule

// ### tb.sv
`timescale 1ns/1ps

module tb;
  localparam logic [31:0] BASE = pci_phase_pkg::TGT_BASE;
  logic        clk_in, reset_in, chip_reset_low_in, frame_in, irdy_in;
  logic        trdy_in, par_in, mst_start_in, mst_write_in, wr_valid_in;
  logic [31:0] ad_in, mst_addr_in, wr_data_in, tgt_rdata_in, ad_out;
  logic [31:0] rd_data_out, tgt_wdata_out, a_ad, a, d, exp_q[$];
  logic [31:0] rd_got[$], tg_got[$], cyc = 32'h0, miss_a[3];
  logic [3:0]  cbe_in, mst_cmd_in, mst_count_in, cbe_out, a_cbe, miss_c[3];
  logic        frame_out, frame_oe_out, irdy_out, irdy_oe_out, trdy_out;
  logic        trdy_oe_out, par_out, par_oe_out, ad_oe_out, cbe_oe_out;
  logic        mst_busy_out, wr_ready_out, rd_valid_out, tgt_wvalid_out;
  logic        a_frame, a_frame_oe, a_irdy, a_irdy_oe, a_trdy, a_trdy_oe;
  logic        a_par, a_par_oe, a_ad_oe, a_cbe_oe, p_oe;
  logic [35:0] p_bus;
  integer      seed;
  int          fails = 0, n_tests = 0, n_toe, n0, i, j, n, w;

  // Control lines pulled up; released data lines wander every cycle
  assign frame_in = frame_oe_out ? frame_out : a_frame_oe ? a_frame : 1'b1;
  assign irdy_in = irdy_oe_out ? irdy_out : a_irdy_oe ? a_irdy : 1'b1;
  assign trdy_in = trdy_oe_out ? trdy_out : a_trdy_oe ? a_trdy : 1'b1;
  assign par_in = par_oe_out ? par_out : a_par_oe ? a_par : cyc[0];
  assign ad_in = ad_oe_out ? ad_out : a_ad_oe ? a_ad : cyc ^ 32'h5a5a_5a5a;
  assign cbe_in = cbe_oe_out ? cbe_out : a_cbe_oe ? a_cbe : cyc[3:0];

  pci_phase_handshake pci_phase_handshake_i (.*);

  pci_bus_agent ag (.clk_in(clk_in), .frame_in(frame_in), .irdy_in(irdy_in),
    .trdy_in(trdy_in), .ad_in(ad_in), .cbe_in(cbe_in), .frame_out(a_frame),
    .frame_oe_out(a_frame_oe), .irdy_out(a_irdy), .irdy_oe_out(a_irdy_oe),
    .trdy_out(a_trdy), .trdy_oe_out(a_trdy_oe), .par_out(a_par),
    .par_oe_out(a_par_oe), .ad_out(a_ad), .ad_oe_out(a_ad_oe),
    .cbe_out(a_cbe), .cbe_oe_out(a_cbe_oe));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run;
    if (fails == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  function automatic logic [31:0] rnd();
    return $random(seed);
  endfunction

  function automatic logic [31:0] even_par(input logic [35:0] b);
    return 32'(^b);
  endfunction

  task automatic chk_idle;
    check("idle pins", 32'({frame_oe_out, irdy_oe_out, trdy_oe_out, ad_oe_out,
      par_oe_out, cbe_oe_out, mst_busy_out, wr_ready_out, frame_out}), 32'h3);
  endtask

  // A second start while busy must be dropped without a new address phase
  task automatic go(input logic wr, input logic [31:0] ad,
                    input logic [3:0] c);
    n0 = ag.n_addr;
    {mst_write_in, mst_addr_in, mst_count_in} = {wr, ad, c};
    mst_cmd_in = wr ? pci_phase_pkg::CMD_MEM_WRITE
                    : pci_phase_pkg::CMD_MEM_READ;
    mst_start_in = 1'b1;
    repeat (2) @(negedge clk_in);
    mst_start_in = 1'b0;
    check("busy", 32'(mst_busy_out), 32'h1);
    w = 0;
    while (mst_busy_out !== 1'b0 && w < 3000) begin
      @(negedge clk_in);
      w++;
    end
    check("busy end", 32'(mst_busy_out), 32'h0);
    repeat (8) @(negedge clk_in);
    check("address phases", ag.n_addr - n0, 32'h1);
  endtask

  always @(posedge clk_in) begin
    cyc <= cyc + 32'h1;
    if (rd_valid_out === 1'b1) rd_got.push_back(rd_data_out);
    if (tgt_wvalid_out === 1'b1) tg_got.push_back(tgt_wdata_out);
    if (trdy_oe_out === 1'b1) n_toe++;
    if (par_oe_out === 1'b1) begin
      check("parity", 32'(par_out), even_par(p_bus));
      check("parity owner", 32'(p_oe), 32'h1);
    end
    p_bus <= {ad_in, cbe_in};
    p_oe <= ad_oe_out;
    if (cyc == 32'd30000) begin
      fails++;
      complete_run();
    end
  end

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h572d8155;
    {reset_in, chip_reset_low_in, mst_start_in, mst_write_in} = 4'b1100;
    {mst_addr_in, mst_cmd_in, mst_count_in, wr_valid_in} = 41'h0;
    {wr_data_in, tgt_rdata_in} = 64'h0;
    repeat (4) @(negedge clk_in);
    reset_in = 1'b0;
    chk_idle();
    for (w = 0; wr_ready_out === 1'b1 && w < 12; w++) begin
      {wr_data_in, wr_valid_in} = {rnd(), 1'b1};
      exp_q.push_back(wr_data_in);
      @(negedge clk_in);
    end
    wr_data_in = rnd();
    repeat (2) @(negedge clk_in);
    wr_valid_in = 1'b0;
    check("fifo depth", w, 32'h8);
    ag.stall = 2;
    a = rnd();
    go(1'b1, a, 4'h8);
    check("address seen", ag.last_addr, a);
    check("command seen", 32'(ag.last_cmd), 32'h7);
    check("words sent", ag.wr_q.size(), 32'h8);
    for (i = 0; i < 8; i++) begin
      check("write word", ag.wr_q[i], exp_q[i]);
      check("frame at phase", 32'(ag.last_q[i]), 32'(i == 7));
    end
    for (i = 0; i < 4; i++) begin
      n = (i == 0) ? 1 : i;
      rd_got.delete();
      exp_q.delete();
      for (j = 0; j < n; j++) begin
        d = rnd();
        exp_q.push_back(d);
        ag.rd_q.push_back(d);
      end
      ag.stall = int'(rnd() % 32'h4);
      go(1'b0, rnd(), 4'(i));
      check("read words", rd_got.size(), n);
      for (j = 0; j < n; j++) check("read word", rd_got[j], exp_q[j]);
    end
    {wr_data_in, wr_valid_in, ag.stall} = {rnd(), 1'b1, 32'd12};
    @(negedge clk_in);
    {wr_valid_in, mst_write_in, mst_count_in, mst_start_in} = 7'b0_1_0001_1;
    @(negedge clk_in);
    mst_start_in = 1'b0;
    repeat (4) @(negedge clk_in);
    // Far shorter than the system minimum to keep the run short
    chip_reset_low_in = 1'b0;
    repeat (5) @(negedge clk_in);
    chk_idle();
    chip_reset_low_in = 1'b1;
    repeat (40) @(negedge clk_in);
    miss_a = '{BASE ^ 32'h0001_0000, BASE, ~BASE};
    miss_c = '{4'h7, 4'h3, 4'h6};
    {n_toe, ag.stall} = 64'h0;
    tg_got.delete();
    for (i = 0; i < 3; i++) ag.initiate(miss_a[i], miss_c[i], 1);
    check("ignored cycles", n_toe + tg_got.size(), 32'h0);
    ag.init_q.delete();
    exp_q.delete();
    for (j = 0; j < 3; j++) begin
      exp_q.push_back(rnd());
      ag.init_q.push_back(exp_q[j]);
    end
    a = BASE | (rnd() & 32'h0000_fffc);
    ag.initiate(a, pci_phase_pkg::CMD_MEM_WRITE, 3);
    check("target words", tg_got.size(), 32'h3);
    for (j = 0; j < 3; j++) check("target word", tg_got[j], exp_q[j]);
    tgt_rdata_in = rnd();
    ag.got_q.delete();
    ag.initiate(a, pci_phase_pkg::CMD_MEM_READ, 1);
    check("target read", ag.got_q[0], tgt_rdata_in);
    complete_run();
  end
endmodule
